// file: dpw_regs.svh
// Verb codes, node numbers, fixed answers and reset values of the digital pin widgets
`ifndef DPW_REGS_SVH
`define DPW_REGS_SVH

`define DPW_NODE_PRIMARY 7'h2d
`define DPW_NODE_SECONDARY 7'h2e
`define DPW_NODE_RX 7'h2f
`define DPW_NODE_BEEP 7'h22

`define DPW_VERB_GET_PARAM 12'hf00
`define DPW_VERB_GET_CONN 12'hf02
`define DPW_VERB_GET_PS 12'hf05
`define DPW_VERB_SET_PS 12'h705
`define DPW_VERB_GET_PCTL 12'hf07
`define DPW_VERB_SET_PCTL 12'h707
`define DPW_VERB_GET_CFG 12'hf1c
`define DPW_VERB_SET_CFG0 12'h71c
`define DPW_VERB_SET_CFG1 12'h71d
`define DPW_VERB_SET_CFG2 12'h71e
`define DPW_VERB_SET_CFG3 12'h71f

`define DPW_PARAM_WCAPS 8'h09
`define DPW_PARAM_PINCAPS 8'h0c
`define DPW_PARAM_CONN_LEN 8'h0e
`define DPW_PARAM_PS_SUP 8'h0f

`define DPW_WCAPS_TX 32'h00400701
`define DPW_WCAPS_RX 32'h00400601
`define DPW_WCAPS_BEEP 32'h0070040c
`define DPW_PINCAPS_TX 32'h00000010
`define DPW_PINCAPS_RX 32'h00000030
`define DPW_CONN_LEN 32'h00000001
`define DPW_PS_SUP 32'h0000000f
`define DPW_CONN_PRIMARY 32'h0000000e
`define DPW_CONN_SECONDARY 32'h0000000f
`define DPW_PS_CTRL_RST 32'h00000400

`define DPW_CFG_RST_PRIMARY 32'h074411f0
`define DPW_CFG_RST_SECONDARY 32'h985601f0
`define DPW_CFG_RST_RX 32'h07c421f0

`define DPW_PCTL_MASK_TX 8'h40
`define DPW_PCTL_MASK_RX 8'h60
`define DPW_PCTL_OE_BIT 6
`define DPW_PCTL_IE_BIT 5
`define DPW_PS_MAX 8'h03
`define DPW_PS_D0 4'h0
`define DPW_PINCAPS_DISP_BIT 7
`define DPW_PORT_CONN_NONE 2'h1

`endif

// file: dpw_pkg.sv
// Types shared by the digital pin widget verb block
package dpw_pkg;

	// One command word as it arrives from the link controller
	typedef struct packed {
		logic [3:0] codec_addr;
		logic indirect;
		logic [6:0] node_identifier;
		logic [11:0] verb;
		logic [7:0] payload;
	} dpw_cmd_t;

	// Settable state of one pin widget
	typedef struct packed {
		logic [3:0] power_state_request;
		logic [3:0] power_state_actual;
		logic settings_reset_flag;
		logic [7:0] pin_control_byte;
		logic [31:0] config_default;
	} dpw_pin_t;

	// Command handling sequence, one bit changing per step from idle through decode to respond
	typedef enum logic [1:0] {
		DPW_IDLE = 2'h0,
		DPW_DECODE = 2'h1,
		DPW_RESPOND = 2'h3
	} dpw_state_t;

endpackage

// file: dpw_verbs.sv
// Verb decoder and parameter store for three digital pin widgets and the beep widget
`timescale 1ns/100ps
`include "dpw_regs.svh"

// Function
// RL1 - Set power state payload 0..3 requests D0..D3
// RL2 - Power response: requested 3:0, actual 7:4
// RL3 - Transmit pins: only output enable writable
// RL4 - Receive pin: output and input enable writable
// RL5 - Config default written bytewise, read whole
// RL6 - Primary config default resets to 074411F0
// RL7 - Secondary config default resets to 985601F0
// RL8 - Receive config default resets to 07C421F0
// RL9 - Secondary widget capabilities answer 00400701
// RL10 - Receive widget capabilities 00400601, no list
// RL11 - Pin caps: secondary 10h, receive 30h
// RL12 - Secondary display flag from controls and config
// RL13 - Transmit pins report one-entry short list
// RL14 - Secondary connection entry is node 0Fh
// RL15 - Primary connection entry is node 0Eh
// RL16 - Pins and beep support D0 to D3
// RL17 - Beep widget at 22h answers 0070040C
// RL18 - Node 2Eh secondary, 2Fh receive pin
// RL19 - Power control response resets to 00000400
// RL20 - Node 2Dh selects primary transmit pin
// RL21 - Read-only fields ignore writes, fixed values
// RL22 - Config byte write touches own byte only
module dpw_verbs
	import dpw_pkg::*;
(
	// Clock and reset
	input wire logic i_clock,
	input wire logic i_nrst,
	// Link from the controller, asynchronous to i_clock
	input wire logic i_link_clk,
	input wire logic i_link_nrst,
	input wire logic i_cmd_valid,
	input wire dpw_cmd_t i_cmd,
	// Second transmitter display-link controls, asynchronous
	input wire logic i_second_tx_display_select,
	input wire logic i_second_tx_display_enable,
	// Response back to the link
	output logic [31:0] o_resp,
	output logic o_resp_valid,
	// Pin enables, driven only while the widget is in D0
	output logic o_primary_tx_oe,
	output logic o_secondary_tx_oe,
	output logic o_rx_pin_ie,
	output logic o_external_amp_powerdown_oe
);

	localparam int NPIN = 3;
	localparam int PRI = 0;
	localparam int SEC = 1;
	localparam int RXP = 2;

	// Two-flop synchronisers; stage one is read by stage two only
	logic link_clk_s1_reg;
	logic link_clk_s2_reg;
	logic link_clk_s3_reg; // Previous synchronised level for edge finding
	logic link_nrst_s1_reg;
	logic link_nrst_s2_reg;
	logic valid_s1_reg;
	logic valid_s2_reg;
	dpw_cmd_t cmd_s1_reg;
	dpw_cmd_t cmd_s2_reg;
	logic disp_sel_s1_reg;
	logic disp_sel_s2_reg;
	logic disp_en_s1_reg;
	logic disp_en_s2_reg;

	// Captured command and handling state
	dpw_cmd_t cmd_reg;
	dpw_state_t state_reg;
	dpw_state_t state_next;
	logic link_rise;

	// Widget state
	dpw_pin_t pin_reg [NPIN];

	// Decode results
	logic [NPIN-1:0] sel;
	logic sel_beep;
	logic [31:0] resp_next;
	logic disp_cap;

	// Synchronise everything that comes from the link or outside pins.
	// The command bus is held by the controller for a whole link period
	// (many i_clock cycles), so per-bit sampling settles before use.
	always_ff @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			link_clk_s1_reg <= 1'b0;
			link_clk_s2_reg <= 1'b0;
			link_clk_s3_reg <= 1'b0;
			link_nrst_s1_reg <= 1'b0;
			link_nrst_s2_reg <= 1'b0;
			valid_s1_reg <= 1'b0;
			valid_s2_reg <= 1'b0;
			cmd_s1_reg <= '0;
			cmd_s2_reg <= '0;
			disp_sel_s1_reg <= 1'b0;
			disp_sel_s2_reg <= 1'b0;
			disp_en_s1_reg <= 1'b0;
			disp_en_s2_reg <= 1'b0;
		end else begin
			link_clk_s1_reg <= i_link_clk;
			link_clk_s2_reg <= link_clk_s1_reg;
			link_clk_s3_reg <= link_clk_s2_reg;
			link_nrst_s1_reg <= i_link_nrst;
			link_nrst_s2_reg <= link_nrst_s1_reg;
			valid_s1_reg <= i_cmd_valid;
			valid_s2_reg <= valid_s1_reg;
			cmd_s1_reg <= i_cmd;
			cmd_s2_reg <= cmd_s1_reg;
			disp_sel_s1_reg <= i_second_tx_display_select;
			disp_sel_s2_reg <= disp_sel_s1_reg;
			disp_en_s1_reg <= i_second_tx_display_enable;
			disp_en_s2_reg <= disp_en_s1_reg;
		end
	end

	// Rising edge of the link clock, seen after synchronisation
	assign link_rise = link_clk_s2_reg && !link_clk_s3_reg;

	// Node decode; the codec address field is not compared here
	always_comb begin
		sel = '0;
		sel_beep = 1'b0;
		case (cmd_reg.node_identifier)
			`DPW_NODE_PRIMARY: begin
				sel[PRI] = 1'b1; // [RL20]
			end
			`DPW_NODE_SECONDARY: begin
				sel[SEC] = 1'b1; // [RL18]
			end
			`DPW_NODE_RX: begin
				sel[RXP] = 1'b1; // [RL18]
			end
			`DPW_NODE_BEEP: begin
				sel_beep = 1'b1;
			end
			default: begin
				sel = '0;
			end
		endcase
	end

	// Command sequence: wait for a command on a link edge, apply it, answer
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			DPW_IDLE: begin
				if (link_rise && valid_s2_reg) begin
					state_next = DPW_DECODE;
				end
			end
			DPW_DECODE: begin
				state_next = DPW_RESPOND;
			end
			DPW_RESPOND: begin
				state_next = DPW_IDLE;
			end
			default: begin
				state_next = DPW_IDLE;
			end
		endcase
	end

	// State register; a link reset drops any command in flight
	always_ff @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			state_reg <= DPW_IDLE;
		end else if (!link_nrst_s2_reg) begin
			state_reg <= DPW_IDLE;
		end else begin
			state_reg <= state_next;
		end
	end

	// Capture the command word on the link edge that carries it
	always_ff @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			cmd_reg <= '0;
		end else if (state_reg == DPW_IDLE && link_rise && valid_s2_reg) begin
			cmd_reg <= cmd_s2_reg;
		end
	end

	// Widget settings. Link reset restores defaults just like the chip reset,
	// so the settings-reset flag tells software its values were lost.
	always_ff @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			for (int i = 0; i < NPIN; i++) begin
				pin_reg[i].power_state_request <= `DPW_PS_D0;
				pin_reg[i].power_state_actual <= `DPW_PS_D0;
				pin_reg[i].settings_reset_flag <= 1'b1; // [RL19]
				pin_reg[i].pin_control_byte <= 8'h00;
			end
			pin_reg[PRI].config_default <= `DPW_CFG_RST_PRIMARY; // [RL6]
			pin_reg[SEC].config_default <= `DPW_CFG_RST_SECONDARY; // [RL7]
			pin_reg[RXP].config_default <= `DPW_CFG_RST_RX; // [RL8]
		end else if (!link_nrst_s2_reg) begin
			for (int i = 0; i < NPIN; i++) begin
				pin_reg[i].power_state_request <= `DPW_PS_D0;
				pin_reg[i].power_state_actual <= `DPW_PS_D0;
				pin_reg[i].settings_reset_flag <= 1'b1; // [RL19]
				pin_reg[i].pin_control_byte <= 8'h00;
			end
			pin_reg[PRI].config_default <= `DPW_CFG_RST_PRIMARY; // [RL6]
			pin_reg[SEC].config_default <= `DPW_CFG_RST_SECONDARY; // [RL7]
			pin_reg[RXP].config_default <= `DPW_CFG_RST_RX; // [RL8]
		end else begin
			for (int i = 0; i < NPIN; i++) begin
				// Actual state follows the request one cycle later; no slow
				// analog settling is modelled in this block
				pin_reg[i].power_state_actual <= pin_reg[i].power_state_request; // [RL2]
				if (state_reg == DPW_DECODE && sel[i]) begin
					case (cmd_reg.verb)
						`DPW_VERB_SET_PS: begin
							// Payloads above D3 are ignored, request unchanged
							if (cmd_reg.payload <= `DPW_PS_MAX) begin
								pin_reg[i].power_state_request <= cmd_reg.payload[3:0]; // [RL1]
								pin_reg[i].settings_reset_flag <= 1'b0;
							end
						end
						`DPW_VERB_SET_PCTL: begin
							// Only the writable bits follow the payload
							if (i == RXP) begin
								pin_reg[i].pin_control_byte <=
									cmd_reg.payload & `DPW_PCTL_MASK_RX; // [RL4]
							end else begin
								pin_reg[i].pin_control_byte <=
									cmd_reg.payload & `DPW_PCTL_MASK_TX; // [RL3] [RL21]
							end
							pin_reg[i].settings_reset_flag <= 1'b0;
						end
						`DPW_VERB_SET_CFG0: begin
							pin_reg[i].config_default[7:0] <= cmd_reg.payload; // [RL5] [RL22]
							pin_reg[i].settings_reset_flag <= 1'b0;
						end
						`DPW_VERB_SET_CFG1: begin
							pin_reg[i].config_default[15:8] <= cmd_reg.payload; // [RL5] [RL22]
							pin_reg[i].settings_reset_flag <= 1'b0;
						end
						`DPW_VERB_SET_CFG2: begin
							pin_reg[i].config_default[23:16] <= cmd_reg.payload; // [RL5] [RL22]
							pin_reg[i].settings_reset_flag <= 1'b0;
						end
						`DPW_VERB_SET_CFG3: begin
							pin_reg[i].config_default[31:24] <= cmd_reg.payload; // [RL5] [RL22]
							pin_reg[i].settings_reset_flag <= 1'b0;
						end
						default: begin
							// Get verbs and unknown verbs change nothing
							pin_reg[i].settings_reset_flag <= pin_reg[i].settings_reset_flag;
						end
					endcase
				end
			end
		end
	end

	// Display-link capability of the secondary pin: both controls set and
	// the pin not declared as unconnected in its configuration default
	assign disp_cap = disp_sel_s2_reg && disp_en_s2_reg &&
		(pin_reg[SEC].config_default[31:30] != `DPW_PORT_CONN_NONE); // [RL12]

	// Response builder; anything not recognised answers zero
	always_comb begin
		resp_next = 32'h00000000;
		if (sel_beep) begin
			if (cmd_reg.verb == `DPW_VERB_GET_PARAM) begin
				case (cmd_reg.payload)
					`DPW_PARAM_WCAPS: begin
						resp_next = `DPW_WCAPS_BEEP; // [RL17]
					end
					`DPW_PARAM_PS_SUP: begin
						resp_next = `DPW_PS_SUP; // [RL16]
					end
					default: begin
						resp_next = 32'h00000000;
					end
				endcase
			end
		end
		for (int i = 0; i < NPIN; i++) begin
			if (sel[i]) begin
				case (cmd_reg.verb)
					`DPW_VERB_GET_PARAM: begin
						case (cmd_reg.payload)
							`DPW_PARAM_WCAPS: begin
								resp_next = (i == RXP) ? `DPW_WCAPS_RX : `DPW_WCAPS_TX; // [RL9] [RL10]
							end
							`DPW_PARAM_PINCAPS: begin
								if (i == RXP) begin
									resp_next = `DPW_PINCAPS_RX; // [RL11]
								end else begin
									resp_next = `DPW_PINCAPS_TX; // [RL11]
									if (i == SEC) begin
										resp_next[`DPW_PINCAPS_DISP_BIT] = disp_cap; // [RL12]
									end
								end
							end
							`DPW_PARAM_CONN_LEN: begin
								// Receive pin has no connection list at all
								resp_next = (i == RXP) ? 32'h00000000 : `DPW_CONN_LEN; // [RL13]
							end
							`DPW_PARAM_PS_SUP: begin
								resp_next = `DPW_PS_SUP; // [RL16]
							end
							default: begin
								resp_next = 32'h00000000;
							end
						endcase
					end
					`DPW_VERB_GET_CONN: begin
						// A single entry, so the offset index is not examined
						if (i == PRI) begin
							resp_next = `DPW_CONN_PRIMARY; // [RL15]
						end else if (i == SEC) begin
							resp_next = `DPW_CONN_SECONDARY; // [RL14]
						end else begin
							resp_next = 32'h00000000;
						end
					end
					`DPW_VERB_GET_PS: begin
						resp_next = `DPW_PS_CTRL_RST & 32'hfffffbff; // [RL21]
						resp_next[10] = pin_reg[i].settings_reset_flag; // [RL19]
						resp_next[7:4] = pin_reg[i].power_state_actual; // [RL2]
						resp_next[3:0] = pin_reg[i].power_state_request; // [RL2]
					end
					`DPW_VERB_GET_PCTL: begin
						resp_next = {24'h000000, pin_reg[i].pin_control_byte}; // [RL21]
					end
					`DPW_VERB_GET_CFG: begin
						resp_next = pin_reg[i].config_default; // [RL5]
					end
					default: begin
						resp_next = 32'h00000000;
					end
				endcase
			end
		end
	end

	// Response output: the word stands until the next command is answered,
	// the valid flag stands until the next link clock rising edge
	always_ff @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			o_resp <= 32'h00000000;
			o_resp_valid <= 1'b0;
		end else if (!link_nrst_s2_reg) begin
			o_resp <= 32'h00000000;
			o_resp_valid <= 1'b0;
		end else if (state_reg == DPW_DECODE) begin
			o_resp <= resp_next;
			o_resp_valid <= 1'b1;
		end else if (link_rise) begin
			o_resp_valid <= 1'b0;
		end
	end

	// Pin enables: a widget drives or listens only in D0, so a sleeping
	// widget never leaves a pin active behind software's back
	always_ff @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			o_primary_tx_oe <= 1'b0;
			o_secondary_tx_oe <= 1'b0;
			o_rx_pin_ie <= 1'b0;
			o_external_amp_powerdown_oe <= 1'b0;
		end else begin
			o_primary_tx_oe <= pin_reg[PRI].pin_control_byte[`DPW_PCTL_OE_BIT] &&
				(pin_reg[PRI].power_state_actual == `DPW_PS_D0);
			o_secondary_tx_oe <= pin_reg[SEC].pin_control_byte[`DPW_PCTL_OE_BIT] &&
				(pin_reg[SEC].power_state_actual == `DPW_PS_D0);
			o_rx_pin_ie <= pin_reg[RXP].pin_control_byte[`DPW_PCTL_IE_BIT] &&
				(pin_reg[RXP].power_state_actual == `DPW_PS_D0); // [RL4]
			o_external_amp_powerdown_oe <= pin_reg[RXP].pin_control_byte[`DPW_PCTL_OE_BIT] &&
				(pin_reg[RXP].power_state_actual == `DPW_PS_D0); // [RL4]
		end
	end

endmodule

// file: dpw_verbs_sva.sv
// Checker for answer timing and pin enables of the verb block
`timescale 1ns/100ps
module dpw_verbs_chk (
	// Clock and reset
	input wire logic i_clock,
	input wire logic i_nrst,
	// Link side
	input wire logic i_link_clk,
	input wire logic i_link_nrst,
	input wire logic i_cmd_valid,
	// Answer and pin enables
	input wire logic [31:0] o_resp,
	input wire logic o_resp_valid,
	input wire logic o_primary_tx_oe,
	input wire logic o_secondary_tx_oe,
	input wire logic o_rx_pin_ie,
	input wire logic o_external_amp_powerdown_oe
);
	logic [3:0] oe_all; // All pin enables together
	logic [5:0] hold_reg; // Cycles the answer has stood

	assign oe_all = {o_primary_tx_oe, o_secondary_tx_oe, o_rx_pin_ie, o_external_amp_powerdown_oe};

	// Answer may stand at most one link period, so count it
	always_ff @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			hold_reg <= 6'h0;
		end else if (!o_resp_valid) begin
			hold_reg <= 6'h0;
		end else if (hold_reg != 6'h3f) begin
			hold_reg <= hold_reg + 6'h1;
		end
	end

	default clocking cb @(posedge i_clock); endclocking
	default disable iff (!i_nrst);

	a_reset_quiet: assert property ($rose(i_nrst) |-> !o_resp_valid && oe_all == 4'h0)
		else $error("Outputs not quiet after reset");
	a_answer_timely: assert property (
		$rose(i_cmd_valid) && i_link_nrst |-> ##[3:10] $rose(o_resp_valid))
		else $error("Command not answered in time");
	a_drop_on_edge: assert property (
		$rose(i_link_clk) && o_resp_valid |-> ##[1:5] !o_resp_valid)
		else $error("Answer valid not dropped at link edge");
	a_resp_steady: assert property (o_resp_valid && $past(o_resp_valid) |-> $stable(o_resp))
		else $error("Answer word changed while valid");
	a_hold_min: assert property ($rose(o_resp_valid) |-> o_resp_valid [*8])
		else $error("Answer valid too short");
	a_hold_max: assert property (hold_reg <= 6'h1a)
		else $error("Answer valid stood too long");
	a_oe_in_window: assert property ($changed(oe_all) |-> o_resp_valid || !i_link_nrst)
		else $error("Pin enable moved without a verb");
	// Pin enables are registered once more behind the widget state, so
	// they settle one cycle after the answer word is cleared
	a_link_reset_clear: assert property (
		(!i_link_nrst) [*5] |-> oe_all == 4'h0 && !o_resp_valid && o_resp == 32'h0)
		else $error("Link reset did not clear outputs");
	a_quiet_no_cmd: assert property ((!i_cmd_valid) [*8] |-> !$rose(o_resp_valid))
		else $error("Answer without a command");

	c_answer: cover property ($rose(o_resp_valid));
	c_pin_drive: cover property ($rose(o_primary_tx_oe));
	c_link_reset: cover property ((!i_link_nrst) [*4]);
endmodule

// file: dpw_link_host.sv
// Link host model: makes the link clock and carries one verb per frame
`timescale 1ns/100ps
module dpw_link_host
	import dpw_pkg::*;
(
	// Clock
	input wire logic i_clock,
	// Answer from the block
	input wire logic [31:0] i_resp,
	input wire logic i_resp_valid,
	// Link towards the block
	output logic o_link_clk,
	output logic o_cmd_valid,
	output dpw_cmd_t o_cmd
);
	logic [3:0] cnt_reg = 4'h0; // Half period count, 10 cycles
	logic lclk_reg = 1'b0; // Free running 80 ns link clock

	assign o_link_clk = lclk_reg;

	initial begin
		o_cmd_valid = 1'b0;
		o_cmd = '0;
	end

	// Link clock runs free, like the real bit clock
	always @(posedge i_clock) begin
		cnt_reg <= (cnt_reg == 4'h9) ? 4'h0 : cnt_reg + 4'h1;
		if (cnt_reg == 4'h9) begin
			lclk_reg <= ~lclk_reg;
		end
	end

	// Return at the edge that raises the link clock
	task automatic link_rise();
		do @(posedge i_clock); while (!(cnt_reg == 4'h9 && !lclk_reg));
	endtask

	// One verb held for one link period; node field picks the widget
	task automatic send(input dpw_cmd_t c, output logic [31:0] r);
		int n;
		logic low;
		link_rise();
		o_cmd <= c;
		o_cmd_valid <= 1'b1;
		low = 1'b0;
		n = 0;
		do begin
			@(posedge i_clock);
			if (!i_resp_valid) begin
				low = 1'b1;
			end
			n++;
		end while (!(low && i_resp_valid) && n < 20);
		// No answer within the frame gives an unknown word
		r = (low && i_resp_valid) ? i_resp : 32'hx;
		link_rise();
		o_cmd_valid <= 1'b0;
		o_cmd <= ~c;
	endtask
endmodule

// file: dpw_verbs_tb_top.sv
// Self-checking bench for the digital pin widget verb block
`timescale 1ns/100ps
module dpw_verbs_tb_top
	import dpw_pkg::*;
;
	// Clock, resets and display controls
	logic clock = 1'b0;
	logic nrst = 1'b0;
	logic link_nrst = 1'b0;
	logic disp_sel = 1'b0;
	logic disp_en = 1'b0;
	// Link and answer
	logic link_clk;
	logic cmd_valid;
	dpw_cmd_t cmd;
	logic [31:0] resp;
	logic resp_valid;
	wire [3:0] oe; // Primary, secondary, receive input, amp power-down
	int bad_count = 0;
	int cmp_count = 0;
	int p;
	logic [31:0] cfg; // Expected config default

	// 250 MHz clock
	always #2 clock = ~clock;

	dpw_verbs i_dpw_verbs (.i_clock(clock), .i_nrst(nrst), .i_link_clk(link_clk),
		.i_link_nrst(link_nrst), .i_cmd_valid(cmd_valid), .i_cmd(cmd),
		.i_second_tx_display_select(disp_sel), .i_second_tx_display_enable(disp_en),
		.o_resp(resp), .o_resp_valid(resp_valid), .o_primary_tx_oe(oe[3]),
		.o_secondary_tx_oe(oe[2]), .o_rx_pin_ie(oe[1]), .o_external_amp_powerdown_oe(oe[0]));

	dpw_link_host i_dpw_link_host (.i_clock(clock), .i_resp(resp), .i_resp_valid(resp_valid),
		.o_link_clk(link_clk), .o_cmd_valid(cmd_valid), .o_cmd(cmd));

	// Print counts and verdict, then end the run
	task automatic stop_test();
		$display("Comparisons %0d, mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	// Compare one value
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			bad_count++;
			$display("[FAIL] %0t ns: got %h, expected %h", $time, seen, exp);
		end
	endtask

	// Send one verb and compare its answer
	task automatic verb(input logic [6:0] nd, input logic [11:0] vb, input logic [7:0] pl,
		input logic [31:0] exp);
		logic [31:0] r;
		i_dpw_link_host.send({4'h0, 1'b0, nd, vb, pl}, r);
		check(r, exp);
	endtask

	// Hang guard
	initial begin
		#200000;
		bad_count++;
		$display("[FAIL] %0t ns: watchdog expired", $time);
		stop_test();
	end

	initial begin
		repeat (10) @(posedge clock);
		nrst <= 1'b1;
		link_nrst <= 1'b1;
		repeat (5) @(posedge clock);
		// Reset values
		verb(7'h2d, 12'hf1c, 8'h00, 32'h074411f0);
		verb(7'h2e, 12'hf1c, 8'h00, 32'h985601f0);
		verb(7'h2f, 12'hf1c, 8'h00, 32'h07c421f0);
		for (p = 'h2d; p <= 'h2f; p++) begin
			verb(7'(p), 12'hf05, 8'h00, 32'h00000400);
			verb(7'(p), 12'hf07, 8'h00, 32'h0);
		end
		$display("Test reset values done");
		// Fixed parameters
		verb(7'h2e, 12'hf00, 8'h09, 32'h00400701);
		verb(7'h2f, 12'hf00, 8'h09, 32'h00400601);
		verb(7'h2e, 12'hf00, 8'h0c, 32'h00000010);
		verb(7'h2f, 12'hf00, 8'h0c, 32'h00000030);
		verb(7'h2d, 12'hf00, 8'h0e, 32'h00000001);
		verb(7'h2e, 12'hf00, 8'h0e, 32'h00000001);
		verb(7'h2f, 12'hf00, 8'h0e, 32'h00000000);
		verb(7'h2e, 12'hf02, 8'h00, 32'h0000000f);
		verb(7'h2d, 12'hf02, 8'h00, 32'h0000000e);
		verb(7'h22, 12'hf00, 8'h09, 32'h0070040c);
		for (p = 'h2c; p <= 'h2f; p++)
			verb((p == 'h2c) ? 7'h22 : 7'(p), 12'hf00, 8'h0f, 32'h0000000f);
		$display("Test parameters done");
		// Pin control: only the enables stick, pins drive in D0
		for (p = 'h2d; p <= 'h2f; p++)
			verb(7'(p), 12'h707, 8'hff, 32'h0);
		verb(7'h2d, 12'hf07, 8'h00, 32'h40);
		verb(7'h2e, 12'hf07, 8'h00, 32'h40);
		verb(7'h2f, 12'hf07, 8'h00, 32'h60);
		check({28'h0, oe}, 32'hf);
		verb(7'h2f, 12'h707, 8'h20, 32'h0);
		check({28'h0, oe}, 32'he);
		$display("Test pin control done");
		// Every power state, then an out-of-range request
		for (p = 0; p < 4; p++) begin
			verb(7'h2d, 12'h705, 8'(p), 32'h0);
			verb(7'h2d, 12'hf05, 8'h00, {24'h0, 4'(p), 4'(p)});
		end
		verb(7'h2d, 12'h705, 8'h04, 32'h0);
		verb(7'h2d, 12'hf05, 8'h00, 32'h33);
		check({28'h0, oe}, 32'h6);
		$display("Test power states done");
		// Config default byte by byte
		cfg = 32'h074411f0;
		for (p = 0; p < 4; p++) begin
			cfg[8*p +: 8] = 8'hc0 | 8'(p);
			verb(7'h2d, 12'h71c + 12'(p), 8'hc0 | 8'(p), 32'h0);
			verb(7'h2d, 12'hf1c, 8'h00, cfg);
		end
		$display("Test config default done");
		// Display capability flag
		disp_sel <= 1'b1;
		disp_en <= 1'b1;
		verb(7'h2e, 12'hf00, 8'h0c, 32'h00000090);
		verb(7'h2e, 12'h71f, 8'h58, 32'h0);
		verb(7'h2e, 12'hf00, 8'h0c, 32'h00000010);
		verb(7'h2d, 12'hf00, 8'h0c, 32'h00000010);
		$display("Test display flag done");
		// Unknown node, then link reset restores defaults
		verb(7'h10, 12'hf00, 8'h09, 32'h0);
		link_nrst <= 1'b0;
		repeat (10) @(posedge clock);
		link_nrst <= 1'b1;
		repeat (5) @(posedge clock);
		verb(7'h2d, 12'hf1c, 8'h00, 32'h074411f0);
		verb(7'h2d, 12'hf05, 8'h00, 32'h00000400);
		verb(7'h2f, 12'hf07, 8'h00, 32'h0);
		$display("Test link reset done");
		stop_test();
	end
endmodule

bind dpw_verbs dpw_verbs_chk i_dpw_verbs_chk (.i_clock(i_clock), .i_nrst(i_nrst),
	.i_link_clk(i_link_clk), .i_link_nrst(i_link_nrst), .i_cmd_valid(i_cmd_valid),
	.o_resp(o_resp), .o_resp_valid(o_resp_valid), .o_primary_tx_oe(o_primary_tx_oe),
	.o_secondary_tx_oe(o_secondary_tx_oe), .o_rx_pin_ie(o_rx_pin_ie),
	.o_external_amp_powerdown_oe(o_external_amp_powerdown_oe));
